// *** src/eprc_defines.vh ***
// Contract
// - two control registers, each mirrored in set B
// - reset takes reference inputs from bidir pins
// - hw select 1: direction pin switches port
// - shared select 0: separate in/out reference lines
// - hw select 0: register sets switch direction
`ifndef EPRC_DEFINES_VH
`define EPRC_DEFINES_VH

// ----------------------------------------
// register indices, byte address = index * 4
// ----------------------------------------
`define EPRC_IDX_OUT_A 8'h02
`define EPRC_IDX_OUT_B 8'h22
`define EPRC_IDX_IN_A 8'h03
`define EPRC_IDX_IN_B 8'h23
`define EPRC_IDX_STAT 8'h20
`define EPRC_IDX_PORT 8'h21

// ----------------------------------------
// field positions
// ----------------------------------------
`define EPRC_OC_HWDIR 7
`define EPRC_OC_SWDIR 6
`define EPRC_IC_SHARED 4
`define EPRC_IC_DEDIN 3
`define EPRC_PC_SRCSET 0
`define EPRC_PC_INSET 1
`define EPRC_PC_STATIC 2

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define EPRC_RST_OUT 8'h00
`define EPRC_RST_IN 8'h00
`define EPRC_RST_PORT 8'h00
`define EPRC_RESP_OKAY 2'b00
`define EPRC_RESP_SLVERR 2'b10

`endif

// *** src/eprc_sync.v ***
`timescale 1ns/1ps
module eprc_sync #(
  parameter WIDTH = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // eprc_sync

// *** src/eprc_top.v ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "eprc_defines.vh"
module eprc_top #(
  parameter REF_W = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [9:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire field_direction_pin,
  input wire field_odd,
  input wire [REF_W-1:0] bidir_reference_pins_in,
  output wire [REF_W-1:0] bidir_reference_pins_out,
  output wire [REF_W-1:0] bidir_reference_pins_oe,
  input wire [REF_W-1:0] ded_ref_in,
  output wire [REF_W-1:0] ded_ref_out,
  input wire [REF_W-1:0] gen_ref,
  output wire [REF_W-1:0] scaler_ref_in,
  output wire port_dir_out
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [2*REF_W+1:0] sync_s;
  wire field_direction_pin_s;
  wire field_odd_s;
  wire [REF_W-1:0] pin_s;
  wire [REF_W-1:0] ded_s;

  eprc_sync #(
    .WIDTH(2*REF_W+2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({field_direction_pin, field_odd, bidir_reference_pins_in, ded_ref_in}),
    .sync_out(sync_s)
  );

  assign field_direction_pin_s = sync_s[2*REF_W+1];
  assign field_odd_s = sync_s[2*REF_W];
  assign pin_s = sync_s[2*REF_W-1:REF_W];
  assign ded_s = sync_s[REF_W-1:0];

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] out_ctrl_q [0:1];
  reg [7:0] in_ctrl_q [0:1];
  reg [7:0] port_ctrl_q;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_idx_q;
  reg [7:0] w_data_q;
  reg w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  wire do_write;
  wire wr_hit;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_hit = (aw_idx_q == `EPRC_IDX_OUT_A) || (aw_idx_q == `EPRC_IDX_OUT_B) ||
                  (aw_idx_q == `EPRC_IDX_IN_A) || (aw_idx_q == `EPRC_IDX_IN_B) ||
                  (aw_idx_q == `EPRC_IDX_PORT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `EPRC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `EPRC_RESP_OKAY : `EPRC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // registers change only on a bus write or reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_ctrl_q[0] <= `EPRC_RST_OUT;
      out_ctrl_q[1] <= `EPRC_RST_OUT;
      in_ctrl_q[0] <= `EPRC_RST_IN;
      in_ctrl_q[1] <= `EPRC_RST_IN;
      port_ctrl_q <= `EPRC_RST_PORT;
    end else if (do_write && w_strb_q) begin
      case (aw_idx_q)
        `EPRC_IDX_OUT_A: out_ctrl_q[0] <= w_data_q;
        `EPRC_IDX_OUT_B: out_ctrl_q[1] <= w_data_q;
        `EPRC_IDX_IN_A: in_ctrl_q[0] <= w_data_q;
        `EPRC_IDX_IN_B: in_ctrl_q[1] <= w_data_q;
        `EPRC_IDX_PORT: port_ctrl_q <= w_data_q;
        default: port_ctrl_q <= port_ctrl_q;
      endcase
    end
  end

  // ----------------------------------------
  // set selection and direction
  // ----------------------------------------
  wire static_sel;
  wire src_set;
  wire in_set;
  wire [7:0] out_ctrl;
  wire [7:0] in_ctrl;
  wire hw_direction_select;
  wire shared_reference_select;
  wire ded_in_sel;
  wire dir_out;

  // odd field uses set A, even field set B, unless fixed by software
  assign static_sel = port_ctrl_q[`EPRC_PC_STATIC];
  assign src_set = static_sel ? port_ctrl_q[`EPRC_PC_SRCSET] : !field_odd_s;
  assign in_set = static_sel ? port_ctrl_q[`EPRC_PC_INSET] : !field_odd_s;
  assign out_ctrl = out_ctrl_q[src_set];
  assign in_ctrl = in_ctrl_q[in_set];
  assign hw_direction_select = out_ctrl[`EPRC_OC_HWDIR];
  assign shared_reference_select = in_ctrl[`EPRC_IC_SHARED];
  assign ded_in_sel = in_ctrl[`EPRC_IC_DEDIN];
  // pin high means port drives out
  assign dir_out = hw_direction_select ? field_direction_pin_s : out_ctrl[`EPRC_OC_SWDIR];

  // ----------------------------------------
  // reference routing
  // ----------------------------------------
  reg [REF_W-1:0] scaler_ref_q;
  reg [REF_W-1:0] pin_out_q;
  reg [REF_W-1:0] pin_oe_q;
  reg [REF_W-1:0] ded_out_q;
  reg dir_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      scaler_ref_q <= {REF_W{1'b0}};
      pin_out_q <= {REF_W{1'b0}};
      pin_oe_q <= {REF_W{1'b0}};
      ded_out_q <= {REF_W{1'b0}};
      dir_q <= 1'b0;
    end else begin
      dir_q <= dir_out;
      pin_out_q <= gen_ref;
      if (shared_reference_select) begin
        scaler_ref_q <= dir_out ? {REF_W{1'b0}} : pin_s;
        pin_oe_q <= {REF_W{dir_out}};
        ded_out_q <= {REF_W{1'b0}};
      end else if (ded_in_sel) begin
        scaler_ref_q <= ded_s;
        pin_oe_q <= {REF_W{dir_out}};
        ded_out_q <= {REF_W{1'b0}};
      end else begin
        scaler_ref_q <= pin_s;
        pin_oe_q <= {REF_W{1'b0}};
        ded_out_q <= dir_out ? gen_ref : {REF_W{1'b0}};
      end
    end
  end

  assign scaler_ref_in = scaler_ref_q;
  assign bidir_reference_pins_out = pin_out_q;
  assign bidir_reference_pins_oe = pin_oe_q;
  assign ded_ref_out = ded_out_q;
  assign port_dir_out = dir_q;

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [7:0] rd_val;
  reg rd_hit;
  wire [7:0] ar_idx;
  wire [7:0] status;

  assign ar_idx = s_axi_araddr[9:2];
  assign status = {3'b000, field_odd_s, field_direction_pin_s, in_set, src_set, dir_out};
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @* begin
    rd_hit = 1'b1;
    case (ar_idx)
      `EPRC_IDX_OUT_A: rd_val = out_ctrl_q[0];
      `EPRC_IDX_OUT_B: rd_val = out_ctrl_q[1];
      `EPRC_IDX_IN_A: rd_val = in_ctrl_q[0];
      `EPRC_IDX_IN_B: rd_val = in_ctrl_q[1];
      `EPRC_IDX_PORT: rd_val = port_ctrl_q;
      `EPRC_IDX_STAT: rd_val = status;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `EPRC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_val};
      rresp_q <= rd_hit ? `EPRC_RESP_OKAY : `EPRC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // eprc_top

// *** tb/eprc_top_asserts.sv ***
`timescale 1ns/1ps
module eprc_top_asserts #(
  parameter REF_W = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire field_direction_pin,
  input wire field_odd,
  input wire [REF_W-1:0] bidir_reference_pins_oe,
  input wire [REF_W-1:0] ded_ref_out,
  input wire [REF_W-1:0] scaler_ref_in,
  input wire port_dir_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence quiet4;
    ($stable(field_direction_pin) && $stable(field_odd) && !s_axi_bvalid) [*4];
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  reset_route_a: assert property ($rose(aresetn) |-> scaler_ref_in == 0 && bidir_reference_pins_oe == 0)
    else $error("outputs not cleared by reset");
  drive_dir_a: assert property (|bidir_reference_pins_oe |-> port_dir_out)
    else $error("pins driven while port is input");
  ded_out_a: assert property (|ded_ref_out |-> port_dir_out && bidir_reference_pins_oe == 0)
    else $error("dedicated output with pins driven");
  dir_held_a: assert property (quiet4 |-> $stable(port_dir_out))
    else $error("direction changed without cause");
endmodule // eprc_top_asserts

bind eprc_top eprc_top_asserts #(.REF_W(REF_W)) i_chk (.*);

// *** tb/eprc_far_end.sv ***
`timescale 1ns/1ps
module eprc_far_end #(
  parameter REF_W = 2
) (
  input wire want_out,
  input wire want_odd,
  input wire [REF_W-1:0] src_ref,
  input wire [REF_W-1:0] dev_out,
  input wire [REF_W-1:0] dev_oe,
  output logic field_direction_pin,
  output logic field_odd,
  output logic [REF_W-1:0] pins_in,
  output logic [REF_W-1:0] ded_in
);
  // source drives pins only where the device lets go
  assign pins_in = (dev_oe & dev_out) | (~dev_oe & src_ref);
  assign ded_in = ~src_ref;
  assign field_direction_pin = want_out;
  assign field_odd = want_odd;
endmodule // eprc_far_end

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic field_direction_pin, field_odd, port_dir_out, want_out = 1'h0, want_odd = 1'h1;
  logic [1:0] bidir_reference_pins_in, bidir_reference_pins_out, bidir_reference_pins_oe;
  logic [1:0] ded_ref_in, ded_ref_out, scaler_ref_in, gen_ref = 2'h1, src_ref = 2'h2;
  int fail_count = 0, samples_checked = 0;

  eprc_top #(.REF_W(2)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .field_direction_pin(field_direction_pin), .field_odd(field_odd),
    .bidir_reference_pins_in(bidir_reference_pins_in), .bidir_reference_pins_out(bidir_reference_pins_out),
    .bidir_reference_pins_oe(bidir_reference_pins_oe), .ded_ref_in(ded_ref_in), .ded_ref_out(ded_ref_out),
    .gen_ref(gen_ref), .scaler_ref_in(scaler_ref_in), .port_dir_out(port_dir_out));
  eprc_far_end #(.REF_W(2)) i_far (.want_out(want_out), .want_odd(want_odd), .src_ref(src_ref),
    .dev_out(bidir_reference_pins_out),
    .dev_oe(bidir_reference_pins_oe), .field_direction_pin(field_direction_pin), .field_odd(field_odd),
    .pins_in(bidir_reference_pins_in), .ded_in(ded_ref_in));

  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ----
  // bus and check tasks
  // ----
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!s_axi_bvalid) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, r);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!s_axi_rvalid) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, {24'h0, d});
    chk("rresp", s_axi_rresp, r);
  endtask
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [9:0] adr [5] = '{10'h008, 10'h088, 10'h00c, 10'h08c, 10'h084};
    settle;
    chk("ref from pins", scaler_ref_in, src_ref);
    chk("pins released", bidir_reference_pins_oe, 2'h0);
    foreach (adr[i]) rd(adr[i], 8'h00, 2'h0);
    rd(10'h000, 8'h00, 2'h2);
  endtask
  task automatic t_route;
    wr(10'h084, 8'h04, 2'h0);
    wr(10'h008, 8'h40, 2'h0);
    wr(10'h00c, 8'h08, 2'h0);
    settle;
    chk("dir", port_dir_out, 1'h1);
    chk("ref from ded", scaler_ref_in, 2'h1);
    chk("pins oe", bidir_reference_pins_oe, 2'h3);
    chk("pins out", bidir_reference_pins_out, gen_ref);
    wr(10'h00c, 8'h00, 2'h0);
    settle;
    chk("ded out", ded_ref_out, gen_ref);
    chk("pins oe sep", bidir_reference_pins_oe, 2'h0);
    chk("ref sep", scaler_ref_in, src_ref);
    wr(10'h00c, 8'h10, 2'h0);
    settle;
    chk("pins oe shared", bidir_reference_pins_oe, 2'h3);
    chk("ref shared", scaler_ref_in, 2'h0);
  endtask
  task automatic t_hwdir;
    wr(10'h008, 8'h80, 2'h0);
    want_out <= 1'h1;
    settle;
    chk("pin dir out", port_dir_out, 1'h1);
    want_out <= 1'h0;
    settle;
    chk("pin dir in", port_dir_out, 1'h0);
    wr(10'h008, 8'h40, 2'h0);
    settle;
    chk("sw dir", port_dir_out, 1'h1);
  endtask
  task automatic t_sets;
    wr(10'h008, 8'h00, 2'h0);
    wr(10'h088, 8'h40, 2'h0);
    wr(10'h084, 8'h07, 2'h0);
    settle;
    chk("set b dir", port_dir_out, 1'h1);
    rd(10'h080, 8'h17, 2'h0);
    rd(10'h008, 8'h00, 2'h0);
    rd(10'h088, 8'h40, 2'h0);
    wr(10'h084, 8'h00, 2'h0);
    settle;
    chk("odd field set a", port_dir_out, 1'h0);
    want_odd <= 1'h0;
    settle;
    chk("even field set b", port_dir_out, 1'h1);
    want_odd <= 1'h1;
    wr(10'h080, 8'hff, 2'h2);
    wr(10'h3fc, 8'h00, 2'h2);
    rd(10'h088, 8'h40, 2'h0);
  endtask
  task automatic t_rst2;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    settle;
    chk("ref after reset", scaler_ref_in, src_ref);
    chk("dir after reset", port_dir_out, 1'h0);
    rd(10'h088, 8'h00, 2'h0);
  endtask
  // ----
  // sequence and verdict
  // ----
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_route;
    t_hwdir;
    t_sets;
    t_rst2;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    stop_test;
  end
endmodule // tb
